/* File: src/eac_ext_add_unit.sv */
// Functional notes
// - add-minus-one (primary 31, extended 234) writes source plus carry plus all ones to dest.
// - add-zero (primary 31, extended 202) writes source plus carry plus zero to dest.
// - both operations always update the carry flag, whatever the overflow and record bits say.
// - overflow enable (bit 21) set updates sticky and wrap flags, clear leaves both alone.
// - record bit (bit 31) set writes negative, positive, zero and sticky copy into cr0.
// - when recording, the sticky flag value is copied into the summary position of cr0.
`timescale 1ns/1ns
module eac_ext_add_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eac_pkg::ADDR_W-1:0] paddr,
  input wire logic [eac_pkg::DATA_W-1:0] pwdata,
  output logic [eac_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rfWrEn,
  output logic [eac_pkg::IDX_W-1:0] rfWrAddr,
  output logic [eac_pkg::DATA_W-1:0] rfWrData,
  output logic coutFlag,
  output logic wrapFlag,
  output logic stickyFlag,
  output logic [eac_pkg::CR_W-1:0] cr0Field
);
  import eac_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_OPERAND) || (a == OFF_INSTR) || (a == OFF_RESULT) ||
           (a == OFF_XER) || (a == OFF_CR0) || (a == OFF_STATUS);
  endfunction

  // bits 16-20 are not looked at, any value there is accepted
  function automatic logic opValid(input logic [DATA_W-1:0] w);
    return (w[OPC_HI:OPC_LO] == PRIMARY_OP) &&
           ((w[XO_HI:XO_LO] == XO_ADD_M1) || (w[XO_HI:XO_LO] == XO_ADD_Z));
  endfunction

  function automatic logic opMinus(input logic [DATA_W-1:0] w);
    return w[XO_HI:XO_LO] == XO_ADD_M1;
  endfunction

  // reference sum for checks, carry in the top bit
  function automatic logic [DATA_W:0] refSum(input logic [DATA_W-1:0] a, input logic c,
                                             input logic m);
    return {1'b0, a} + {{DATA_W{1'b0}}, c} + {1'b0, (m ? WORD_ONES : WORD_ZERO)};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] operandR, operandNxt;
  logic [DATA_W-1:0] instrR, instrNxt;
  logic [DATA_W-1:0] resultR, resultNxt;
  logic [DATA_W-1:0] prdataR, prdataNxt;
  logic preadyR, preadyNxt;
  logic pslverrR, pslverrNxt;
  logic coutR, coutNxt;
  logic wrapR, wrapNxt;
  logic stickyR, stickyNxt;
  logic [CR_W-1:0] cr0R, cr0Nxt;
  logic illegalR, illegalNxt;
  logic rfWrEnR, rfWrEnNxt;
  logic [IDX_W-1:0] rfWrAddrR, rfWrAddrNxt;
  logic [DATA_W-1:0] rfWrDataR, rfWrDataNxt;

  logic setupPh;
  logic accessDone;
  logic wrAccess;
  logic execGo;
  logic xerWrite;
  logic [DATA_W-1:0] addSum;
  logic addCarry;
  logic addWrap;

  // ----------------------------------------------------------------
  // bus phase decode
  // ----------------------------------------------------------------
  assign setupPh = psel && !penable;
  assign accessDone = psel && penable && preadyR;
  assign wrAccess = accessDone && pwrite;
  assign execGo = wrAccess && (paddr == OFF_INSTR);
  assign xerWrite = wrAccess && (paddr == OFF_XER);

  // ----------------------------------------------------------------
  // adder, its minus-one select fed straight from the word being written; operand and carry come from the registers
  // ----------------------------------------------------------------
  eac_adder uAdder (
    .opA(operandR),
    .carryIn(coutR),
    .minusOne(opMinus(pwdata)),
    .sum(addSum),
    .carryOut(addCarry),
    .wrapOut(addWrap)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read data is captured in setup so prdata leaves a flop; pready is high in the
  // first access cycle, so no wait state is added and every output stays registered
  always_comb begin
    operandNxt = operandR;
    instrNxt = instrR;
    resultNxt = resultR;
    prdataNxt = prdataR;
    preadyNxt = 1'b0;
    pslverrNxt = pslverrR;
    coutNxt = coutR;
    wrapNxt = wrapR;
    stickyNxt = stickyR;
    cr0Nxt = cr0R;
    illegalNxt = illegalR;
    rfWrEnNxt = 1'b0;
    rfWrAddrNxt = rfWrAddrR;
    rfWrDataNxt = rfWrDataR;
    if (setupPh) begin
      preadyNxt = 1'b1;
      pslverrNxt = !isMapped(paddr);
      prdataNxt = WORD_ZERO;
      if (!pwrite) begin
        case (paddr)
          OFF_OPERAND: prdataNxt = operandR;
          OFF_INSTR: prdataNxt = instrR;
          OFF_RESULT: prdataNxt = resultR;
          OFF_XER: begin
            prdataNxt[XER_CA] = coutR;
            prdataNxt[XER_OV] = wrapR;
            prdataNxt[XER_SO] = stickyR;
          end
          OFF_CR0: prdataNxt[CR_W-1:0] = cr0R;
          OFF_STATUS: begin
            prdataNxt[ST_ILLEGAL] = illegalR;
            prdataNxt[ST_DST_LO +: IDX_W] = instrR[DST_HI:DST_LO];
            prdataNxt[ST_SRC_LO +: IDX_W] = instrR[SRC_HI:SRC_LO];
          end
          default: prdataNxt = WORD_ZERO;
        endcase
      end
    end
    // software write of the flags; a wrap written as one also sets sticky
    if (xerWrite) begin
      coutNxt = pwdata[XER_CA];
      wrapNxt = pwdata[XER_OV];
      stickyNxt = pwdata[XER_SO] || pwdata[XER_OV];
    end
    if (wrAccess && (paddr == OFF_OPERAND)) begin
      operandNxt = pwdata;
    end
    // execute on the instruction write itself
    if (execGo) begin
      instrNxt = pwdata;
      if (opValid(pwdata)) begin
        illegalNxt = 1'b0;
        resultNxt = addSum;
        rfWrEnNxt = 1'b1;
        rfWrAddrNxt = pwdata[DST_HI:DST_LO];
        rfWrDataNxt = addSum;
        coutNxt = addCarry;
        if (pwdata[OE_POS]) begin
          wrapNxt = addWrap;
          stickyNxt = stickyR || addWrap;
        end
        if (pwdata[RC_POS]) begin
          cr0Nxt[CR_LT] = addSum[DATA_W-1];
          cr0Nxt[CR_GT] = !addSum[DATA_W-1] && (addSum != WORD_ZERO);
          cr0Nxt[CR_EQ] = addSum == WORD_ZERO;
          cr0Nxt[CR_SO] = stickyNxt;
        end
      end else begin
        // unknown encodings set the illegal flag and leave every other flag and the result alone
        illegalNxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operandR <= WORD_ZERO;
      instrR <= WORD_ZERO;
      resultR <= WORD_ZERO;
      prdataR <= WORD_ZERO;
      preadyR <= 1'b0;
      pslverrR <= 1'b0;
      coutR <= 1'b0;
      wrapR <= 1'b0;
      stickyR <= 1'b0;
      cr0R <= CR_RESET;
      illegalR <= 1'b0;
      rfWrEnR <= 1'b0;
      rfWrAddrR <= IDX_RESET;
      rfWrDataR <= WORD_ZERO;
    end else begin
      operandR <= operandNxt;
      instrR <= instrNxt;
      resultR <= resultNxt;
      prdataR <= prdataNxt;
      preadyR <= preadyNxt;
      pslverrR <= pslverrNxt;
      coutR <= coutNxt;
      wrapR <= wrapNxt;
      stickyR <= stickyNxt;
      cr0R <= cr0Nxt;
      illegalR <= illegalNxt;
      rfWrEnR <= rfWrEnNxt;
      rfWrAddrR <= rfWrAddrNxt;
      rfWrDataR <= rfWrDataNxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdataR;
  assign pready = preadyR;
  assign pslverr = pslverrR;
  assign rfWrEn = rfWrEnR;
  assign rfWrAddr = rfWrAddrR;
  assign rfWrData = rfWrDataR;
  assign coutFlag = coutR;
  assign wrapFlag = wrapR;
  assign stickyFlag = stickyR;
  assign cr0Field = cr0R;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cbChk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sExecAny;
    execGo && opValid(pwdata);
  endsequence

  sequence sExecM1;
    execGo && opValid(pwdata) && opMinus(pwdata);
  endsequence

  sequence sExecZ;
    execGo && opValid(pwdata) && !opMinus(pwdata);
  endsequence

  sequence sExecBad;
    execGo && !opValid(pwdata);
  endsequence

  chk_minus_one_sum: assert property (sExecM1 |=>
      {coutR, resultR} == refSum($past(operandR), $past(coutR), 1'b1) && rfWrEnR)
    else $error("minus-one sum or carry wrong");

  chk_zero_ext_sum: assert property (sExecZ |=>
      resultR == rfWrDataR && rfWrEnR && !$past(rfWrEnR) &&
      {coutR, rfWrDataR} == refSum($past(operandR), $past(coutR), 1'b0))
    else $error("zero-extended sum or carry wrong");

  chk_dest_index: assert property (sExecAny |=>
      rfWrAddrR == $past(pwdata[DST_HI:DST_LO]))
    else $error("result written to wrong destination");

  // an unknown word must not touch the result, the carry or the file port
  chk_illegal_quiet: assert property (sExecBad |=>
      !rfWrEnR && illegalR && coutR == $past(coutR) && resultR == $past(resultR))
    else $error("unknown encoding changed state");

  chk_carry_always: assert property (
      (sExecAny and (!pwdata[OE_POS] && !pwdata[RC_POS])) |=>
      {coutR, resultR} == refSum($past(operandR), $past(coutR), $past(opMinus(pwdata))))
    else $error("carry not updated on plain form");

  chk_ovf_hold: assert property ((sExecAny and !pwdata[OE_POS]) |=>
      wrapR == $past(wrapR) && stickyR == $past(stickyR))
    else $error("overflow flags moved with enable clear");

  chk_record_field: assert property ((sExecAny and pwdata[RC_POS]) |=>
      cr0R[CR_LT] == resultR[DATA_W-1] && cr0R[CR_EQ] == (resultR == WORD_ZERO) &&
      cr0R[CR_GT] == (!resultR[DATA_W-1] && resultR != WORD_ZERO))
    else $error("cr0 sign bits wrong");

  chk_record_hold: assert property ((sExecAny and !pwdata[RC_POS]) |=>
      cr0R == $past(cr0R))
    else $error("cr0 changed with record clear");

  chk_summary_copy: assert property ((sExecAny and pwdata[RC_POS]) |=>
      cr0R[CR_SO] == stickyR)
    else $error("cr0 summary bit not the sticky flag");

  chk_wrap_minus: assert property ((sExecM1 and pwdata[OE_POS]) |=>
      wrapR == ($past(operandR[DATA_W-1]) && !resultR[DATA_W-1]) && (stickyR || !wrapR))
    else $error("wrap wrong for minus-one form");

  chk_wrap_zero: assert property ((sExecZ and pwdata[OE_POS]) |=>
      wrapR == (!$past(operandR[DATA_W-1]) && resultR[DATA_W-1]) && (stickyR || !wrapR))
    else $error("wrap wrong for zero form");

  chk_sticky_stays: assert property ((stickyR && !xerWrite) |=> stickyR)
    else $error("sticky overflow dropped without a write");

  chk_apb_ready: assert property (setupPh |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

endmodule // eac_ext_add_unit

/* File: pkg/eac_pkg.sv */
package eac_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned CR_W = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_OPERAND = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_XER = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CR0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // instruction word fields, bit 0 of the encoding is our bit 31
  // ----------------------------------------------------------------
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned DST_HI = 25;
  localparam int unsigned DST_LO = 21;
  localparam int unsigned SRC_HI = 20;
  localparam int unsigned SRC_LO = 16;
  localparam int unsigned OE_POS = 10;
  localparam int unsigned XO_HI = 9;
  localparam int unsigned XO_LO = 1;
  localparam int unsigned RC_POS = 0;

  localparam logic [5:0] PRIMARY_OP = 6'h1f;
  localparam logic [8:0] XO_ADD_M1 = 9'h0ea;
  localparam logic [8:0] XO_ADD_Z = 9'h0ca;

  // ----------------------------------------------------------------
  // flag positions inside the exception, cr0 and status words
  // ----------------------------------------------------------------
  localparam int unsigned XER_CA = 0;
  localparam int unsigned XER_OV = 1;
  localparam int unsigned XER_SO = 2;
  localparam int unsigned CR_SO = 0;
  localparam int unsigned CR_EQ = 1;
  localparam int unsigned CR_GT = 2;
  localparam int unsigned CR_LT = 3;
  localparam int unsigned ST_ILLEGAL = 0;
  localparam int unsigned ST_DST_LO = 8;
  localparam int unsigned ST_SRC_LO = 16;

  // ----------------------------------------------------------------
  // constant words and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_ONES = 32'hffff_ffff;
  localparam logic [CR_W-1:0] CR_RESET = 4'h0;
  localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;

endpackage

/* File: src/eac_adder.sv */
`timescale 1ns/1ns
module eac_adder (
  input wire logic [eac_pkg::DATA_W-1:0] opA,
  input wire logic carryIn,
  input wire logic minusOne,
  output logic [eac_pkg::DATA_W-1:0] sum,
  output logic carryOut,
  output logic wrapOut
);
  import eac_pkg::*;

  logic [DATA_W-1:0] opB;
  logic [DATA_W:0] wide;

  // ----------------------------------------------------------------
  // three input add: operand, carry in, all ones or zero
  // ----------------------------------------------------------------
  always_comb begin
    opB = minusOne ? WORD_ONES : WORD_ZERO;
    wide = {1'b0, opA} + {1'b0, opB} + {{DATA_W{1'b0}}, carryIn};
    sum = wide[DATA_W-1:0];
    carryOut = wide[DATA_W];
    // signed wrap: like signs in, other sign out
    wrapOut = (opA[DATA_W-1] == opB[DATA_W-1]) && (sum[DATA_W-1] != opA[DATA_W-1]);
  end

endmodule // eac_adder

/* File: verification/eac_rf_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// register file seen from the result port
// ----------------------------------------
module eac_rf_model (
  input wire logic clk,
  input wire logic rfWrEn,
  input wire logic [eac_pkg::IDX_W-1:0] rfWrAddr,
  input wire logic [eac_pkg::DATA_W-1:0] rfWrData,
  output logic [7:0] wrCount,
  output logic [eac_pkg::IDX_W-1:0] lastAddr,
  output logic [eac_pkg::DATA_W-1:0] lastData
);
  import eac_pkg::*;
  logic [DATA_W-1:0] gpr [32];
  // counter starts clean, the unit has no say over it
  logic [7:0] wrCountQ = 8'h00;
  // data comes back out of the array, so the stored word is what gets compared
  assign lastData = gpr[lastAddr];
  assign wrCount = wrCountQ;
  // only a clean high pulse is a write, unknowns before reset are ignored
  always @(posedge clk) begin
    if (rfWrEn === 1'b1) begin
      gpr[rfWrAddr] <= rfWrData;
      lastAddr <= rfWrAddr;
      wrCountQ <= wrCountQ + 8'h01;
    end
  end
endmodule // eac_rf_model

/* File: verification/tb_extended_add_carry_unit.sv */
`timescale 1ns/1ns
module tb_extended_add_carry_unit;
  import eac_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [2:0] xer;
    logic [3:0] ctl;
  } eac_row_t;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata, rfWrData, lastData;
  logic pready, pslverr, rfWrEn, coutFlag, wrapFlag, stickyFlag;
  logic [IDX_W-1:0] rfWrAddr, lastAddr;
  logic [CR_W-1:0] cr0Field;
  logic [7:0] wrCount;
  int errCount = 0;
  int samplesChecked = 0;
  eac_row_t rows [13];

  // 10 MHz core clock
  always #50 clk = ~clk;

  eac_ext_add_unit eac_ext_add_unit_i (.clk(clk), .rst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rfWrEn(rfWrEn), .rfWrAddr(rfWrAddr),
    .rfWrData(rfWrData), .coutFlag(coutFlag), .wrapFlag(wrapFlag),
    .stickyFlag(stickyFlag), .cr0Field(cr0Field));
  eac_rf_model eac_rf_model_i (.clk(clk), .rfWrEn(rfWrEn), .rfWrAddr(rfWrAddr),
    .rfWrData(rfWrData), .wrCount(wrCount), .lastAddr(lastAddr), .lastData(lastData));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; idles a cycle first so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // the wait takes any latency, then checks it was one cycle; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h0000_0001, "pready latency");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                     input string what);
    logic [DATA_W-1:0] rd;
    logic e;
    apb(1'b0, a, WORD_ZERO, rd, e);
    chk(rd, exp, what);
  endtask

  function automatic logic [DATA_W-1:0] mk(input logic [4:0] d, input logic oe,
                                           input logic [8:0] xo, input logic rc);
    return {PRIMARY_OP, d, 5'h04, 5'h00, oe, xo, rc};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    eac_row_t r;
    logic [4:0] d;
    logic [DATA_W-1:0] b, s, rd;
    logic [DATA_W:0] s33;
    logic v, e;
    logic [2:0] expX;
    logic [3:0] expCr;
    logic [7:0] cnt;
    // ctl is {write xer first, minus one, overflow enable, record}
    rows = '{{32'h9000_3000, 3'b000, 4'b1100}, {32'hb000_42ff, 3'b000, 4'b1101},
             {32'h8000_0000, 3'b000, 4'b1110}, {32'h8000_0000, 3'b101, 4'b1111},
             {32'h0000_0001, 3'b110, 4'b1100}, {32'h0000_0000, 3'b000, 4'b0101},
             {32'h7b41_92c0, 3'b000, 4'b1000}, {32'hefff_ffff, 3'b001, 4'b1001},
             {32'h9000_3000, 3'b001, 4'b1010}, {32'h7fff_ffff, 3'b001, 4'b1011},
             {32'hffff_ffff, 3'b001, 4'b1001}, {32'h0000_0005, 3'b000, 4'b0001},
             {32'h0000_0000, 3'b000, 4'b1111}};
    repeat (16) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    rdc(OFF_XER, WORD_ZERO, "xer after reset");
    rdc(OFF_CR0, WORD_ZERO, "cr0 after reset");
    apb(1'b0, 8'h40, WORD_ZERO, rd, e);
    chk({31'h0, e}, 32'h1, "unmapped read");
    chk(rd, WORD_ZERO, "unmapped read data");
    apb(1'b1, 8'h40, WORD_ONES, rd, e);
    chk({31'h0, e}, 32'h1, "unmapped write");
    expX = 3'b000;
    expCr = 4'h0;
    // rows without an xer write chain the carry of the previous op
    foreach (rows[i]) begin
      r = rows[i];
      d = 5'(i + 1);
      if (r.ctl[3]) begin
        wr(OFF_XER, {29'h0, r.xer});
        expX = r.xer;
      end
      wr(OFF_OPERAND, r.a);
      b = r.ctl[2] ? WORD_ONES : WORD_ZERO;
      cnt = wrCount;
      wr(OFF_INSTR, mk(d, r.ctl[1], r.ctl[2] ? XO_ADD_M1 : XO_ADD_Z, r.ctl[0]));
      s33 = {1'b0, r.a} + {1'b0, b} + {32'h0, expX[0]};
      s = s33[DATA_W-1:0];
      v = (r.a[31] == b[31]) && (s[31] != r.a[31]);
      expX[0] = s33[DATA_W];
      if (r.ctl[1]) begin
        expX[1] = v;
        expX[2] = expX[2] | v;
      end
      if (r.ctl[0]) begin
        expCr = {s[31], ~s[31] & (s != WORD_ZERO), s == WORD_ZERO, expX[2]};
      end
      rdc(OFF_RESULT, s, "result word");
      chk(lastData, s, "rf data");
      chk({27'h0, lastAddr}, {27'h0, d}, "rf dest");
      chk({24'h0, wrCount}, {24'h0, cnt + 8'h01}, "rf writes");
      rdc(OFF_XER, {29'h0, expX}, "xer word");
      chk({29'h0, stickyFlag, wrapFlag, coutFlag}, {29'h0, expX}, "flags");
      rdc(OFF_CR0, {28'h0, expCr}, "cr0 word");
      chk({28'h0, cr0Field}, {28'h0, expCr}, "cr0 port");
    end
    // unknown extended opcode must only set the illegal status and keep the new instruction word
    cnt = wrCount;
    wr(OFF_INSTR, mk(5'h03, 1'b1, 9'h0c8, 1'b1));
    b = WORD_ZERO;
    b[ST_ILLEGAL] = 1'b1;
    b[ST_DST_LO +: IDX_W] = 5'h03;
    b[ST_SRC_LO +: IDX_W] = 5'h04;
    rdc(OFF_STATUS, b, "status word");
    rdc(OFF_INSTR, mk(5'h03, 1'b1, 9'h0c8, 1'b1), "instr readback");
    rdc(OFF_OPERAND, r.a, "operand readback");
    chk({24'h0, wrCount}, {24'h0, cnt}, "illegal wrote");
    rdc(OFF_XER, {29'h0, expX}, "illegal xer");
    wr(OFF_RESULT, WORD_ONES);
    rdc(OFF_RESULT, s, "result read only");
    endSim();
  end

  // watchdog, far beyond the 87 transfers above
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    endSim();
  end
endmodule // tb_extended_add_carry_unit
